/* breaker_failure_timer_logic.sv */
// Breaker failure supervision: pick-up criteria, delay timers, events,
// counters and record history. Assumes pick-up comparators, trip contact,
// trigger input and block arrive as asynchronous levels.
`timescale 1ns/1ps
`default_nettype none

module breaker_failure_timer_logic
    import breaker_failure_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS_P = CYCLE_CLKS,
    parameter int unsigned MS_CLKS_P    = MS_CLKS,
    parameter int unsigned HIST_DEPTH   = HIST_DEF
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_phase_pickup,
    input  wire logic        i_residual_pickup,
    input  wire logic        i_trip_contact,
    input  wire logic        i_trigger_input,
    input  wire logic        i_block,
    input  wire logic [15:0] i_max_phase_current,
    input  wire logic [15:0] i_residual_current,
    input  wire logic [2:0]  i_setting_group,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_start,
    output logic             o_retrip,
    output logic             o_breaker_failure_output,
    output logic             o_blocked,
    output logic             o_event_valid,
    output event_t           o_event
);

    localparam int unsigned PW = $clog2(HIST_DEPTH + 1);

    logic [31:0]    div_q;
    logic [31:0]    ms_div_q;
    logic [31:0]    stamp_q;
    logic           tick_q;
    logic [PIN_N-1:0] pin_w;
    logic [PIN_N-1:0] filt_q;
    logic [1:0]     crit_q;
    logic           retrip_en_q;
    logic           sup_cur_q;
    logic           sup_do_q;
    logic [15:0]    retrip_dly_q;
    logic [15:0]    fail_dly_q;
    logic [7:0]     on_mask_q;
    logic [7:0]     off_mask_q;
    bf_state_t      state_q;
    bf_state_t      state_d;
    logic [15:0]    timer_q;
    logic [15:0]    timer_d;
    logic [15:0]    timer_inc_w;
    logic [15:0]    retrip_ticks_w;
    logic [15:0]    fail_ticks_w;
    logic           cur_w;
    logic           trip_w;
    logic           blk_w;
    logic           pick_w;
    logic           retrip_hit_w;
    logic           fail_hit_w;
    logic [EV_N-1:0] mon_w;
    logic [EV_N-1:0] prev_q;
    logic [EV_N-1:0] diff_w;
    logic           ev_hit;
    logic [2:0]     ev_idx;
    logic           store_w;
    logic           rec_w;
    logic [CNT_N-1:0] inc_w;
    logic [CNT_N-1:0] clr_w;
    logic [15:0]    cnt_q [CNT_N];
    record_t        hist_q [HIST_DEPTH];
    record_t        rec_rd_w;
    logic [PW-1:0]  wr_ptr_q;
    logic [PW-1:0]  fill_q;
    logic [PW-1:0]  rec_sel_q;
    logic [PW:0]    back_w;
    logic [PW-1:0]  rd_idx_w;
    logic           rec_ok_w;
    logic [15:0]    to_rtr_w;
    logic [15:0]    to_fail_w;
    logic [31:0]    rdata_w;

    // ------------------------------------------------------------
    // Program cycle tick and millisecond time stamp
    // ------------------------------------------------------------
    // Both rates are enables from two separate free-running dividers, no second clock
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 32'(CYCLE_CLKS_P - 1));
            div_q  <= (div_q == 32'(CYCLE_CLKS_P - 1)) ? '0 : div_q + 32'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ms_div_q <= '0;
            stamp_q  <= '0;
        end else if (ms_div_q == 32'(MS_CLKS_P - 1)) begin
            ms_div_q <= '0;
            stamp_q  <= stamp_q + 32'h1;
        end else begin
            ms_div_q <= ms_div_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign pin_w = {i_block, i_trigger_input, i_trip_contact,
                    i_residual_pickup, i_phase_pickup};

    // Three stages; level accepted only when stages two and three agree
    for (genvar k = 0; k < PIN_N; k++) begin : g_sync
        logic [2:0] sh_q;
        always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
                sh_q      <= '0;
                filt_q[k] <= 1'b0;
            end else begin
                sh_q <= {sh_q[1:0], pin_w[k]};
                if (sh_q[1] == sh_q[2]) begin
                    filt_q[k] <= sh_q[2];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pick-up criterion
    // ------------------------------------------------------------
    assign cur_w  = filt_q[PIN_PH] | filt_q[PIN_RES];
    assign trip_w = filt_q[PIN_TRIP];
    assign blk_w  = filt_q[PIN_BLK];
    assign pick_w = (crit_q == CRIT_CUR) ? cur_w :
                    (crit_q == CRIT_AND) ? (cur_w & trip_w) :
                    (crit_q == CRIT_OR)  ? (cur_w | trip_w) :
                    (filt_q[PIN_DI] & (cur_w | !sup_cur_q)
                                    & (trip_w | !sup_do_q));

    // ------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------
    // Settings are in 5 ms steps, converted to program cycle ticks
    assign retrip_ticks_w = 16'(retrip_dly_q * STEP_TICKS);
    assign fail_ticks_w   = 16'(fail_dly_q * STEP_TICKS);
    assign timer_inc_w    = (timer_q == 16'hFFFF) ? timer_q : timer_q + 16'h1;
    assign retrip_hit_w   = retrip_en_q && (timer_inc_w >= retrip_ticks_w);
    assign fail_hit_w     = timer_inc_w >= fail_ticks_w;

    // One timer serves both outputs since one pick-up starts both
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        if (tick_q) begin
            if (!pick_w) begin
                state_d = ST_NORMAL;
                timer_d = '0;
            end else if (blk_w) begin
                state_d = ST_BLOCKED;
                timer_d = '0;
            end else begin
                timer_d = timer_inc_w;
                state_d = fail_hit_w ? ST_FAIL : retrip_hit_w ? ST_RETRIP : ST_START;
            end
        end
    end

    // Outputs are flops fed from the same next-state decision
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= ST_NORMAL;
            timer_q <= '0;
            o_start <= 1'b0;
            o_retrip <= 1'b0;
            o_breaker_failure_output <= 1'b0;
            o_blocked <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            o_start <= (state_d != ST_NORMAL) && (state_d != ST_BLOCKED);
            o_retrip <= (state_d == ST_RETRIP) || ((state_d == ST_FAIL) && retrip_en_q
                        && (timer_d >= retrip_ticks_w));
            o_breaker_failure_output <= (state_d == ST_FAIL);
            o_blocked <= (state_d == ST_BLOCKED);
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    assign mon_w  = {filt_q[PIN_RES], filt_q[PIN_PH], filt_q[PIN_DI], trip_w,
                     blk_w, o_breaker_failure_output, o_retrip, o_start};
    assign diff_w = mon_w ^ prev_q;

    // Lowest changed bit first; each other waits one cycle per lower change, and is lost if it reverts first
    always_comb begin
        ev_hit = 1'b0;
        ev_idx = '0;
        for (int k = EV_N - 1; k >= 0; k--) begin
            if (diff_w[k]) begin
                ev_hit = 1'b1;
                ev_idx = 3'(k);
            end
        end
    end

    assign store_w = ev_hit && (mon_w[ev_idx] ? on_mask_q[ev_idx] : off_mask_q[ev_idx]);
    assign rec_w   = store_w && mon_w[ev_idx];

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prev_q        <= '0;
            o_event_valid <= 1'b0;
            o_event       <= '0;
        end else begin
            o_event_valid <= store_w;
            if (ev_hit) begin
                prev_q[ev_idx] <= mon_w[ev_idx];
            end
            if (store_w) begin
                o_event <= '{stamp: stamp_q, id: ev_idx, on: mon_w[ev_idx]};
            end
        end
    end

    // ------------------------------------------------------------
    // Cumulative counters
    // ------------------------------------------------------------
    assign inc_w = {state_d == ST_BLOCKED && !o_blocked,
                    state_d != ST_NORMAL && state_d != ST_BLOCKED && !o_start,
                    state_d == ST_FAIL && !o_breaker_failure_output,
                    state_d == ST_RETRIP && !o_retrip};
    assign clr_w = (i_wr && i_addr == REG_CLR) ? i_wdata[CNT_N-1:0] : '0;

    // A count that lands with a clear survives as one
    for (genvar k = 0; k < CNT_N; k++) begin : g_cnt
        always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
                cnt_q[k] <= '0;
            end else if (inc_w[k]) begin
                cnt_q[k] <= clr_w[k] ? 16'h0001 : cnt_q[k] + 16'h0001;
            end else if (clr_w[k]) begin
                cnt_q[k] <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Record history
    // ------------------------------------------------------------
    assign to_rtr_w  = (retrip_ticks_w > timer_q) ? retrip_ticks_w - timer_q : '0;
    assign to_fail_w = (fail_ticks_w > timer_q) ? fail_ticks_w - timer_q : '0;

    // Ring buffer; the newest entry overwrites the oldest
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wr_ptr_q <= '0;
            fill_q   <= '0;
        end else if (rec_w) begin
            hist_q[wr_ptr_q] <= '{stamp: stamp_q, id: ev_idx, group: i_setting_group,
                                  phase: i_max_phase_current, residual: i_residual_current,
                                  to_retrip: to_rtr_w, to_fail: to_fail_w};
            wr_ptr_q <= (wr_ptr_q == PW'(HIST_DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            if (fill_q != PW'(HIST_DEPTH)) begin
                fill_q <= fill_q + PW'(1);
            end
        end
    end

    // Selector 0 reads the newest record
    assign back_w   = (PW+1)'(wr_ptr_q) + (PW+1)'(HIST_DEPTH - 1) - (PW+1)'(rec_sel_q);
    assign rd_idx_w = (back_w >= (PW+1)'(HIST_DEPTH)) ? PW'(back_w - (PW+1)'(HIST_DEPTH))
                                                      : PW'(back_w);
    assign rec_ok_w = rec_sel_q < fill_q;
    assign rec_rd_w = rec_ok_w ? hist_q[rd_idx_w] : '0;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            {sup_do_q, sup_cur_q, retrip_en_q, crit_q} <= CTRL_RST;
            retrip_dly_q <= RETRIP_DEF;
            fail_dly_q   <= FAIL_DEF;
            {off_mask_q, on_mask_q} <= MASK_RST;
            rec_sel_q <= '0;
        end else if (i_wr) begin
            if (i_addr == REG_CTRL) begin
                crit_q      <= i_wdata[CTRL_CRIT +: 2];
                retrip_en_q <= i_wdata[CTRL_RETRIP];
                sup_cur_q   <= i_wdata[CTRL_SUP_CUR];
                sup_do_q    <= i_wdata[CTRL_SUP_DO];
            end
            if (i_addr == REG_RETRIP) retrip_dly_q <= i_wdata[15:0];
            if (i_addr == REG_FAIL) fail_dly_q <= i_wdata[15:0];
            if (i_addr == REG_MASK) {off_mask_q, on_mask_q} <= i_wdata[15:0];
            if (i_addr == REG_R_SEL) rec_sel_q <= i_wdata[PW-1:0];
        end
    end

    // Unmapped offsets read as zero
    assign rdata_w =
        (i_addr == REG_CTRL)   ? {27'h0, sup_do_q, sup_cur_q, retrip_en_q, crit_q} :
        (i_addr == REG_RETRIP) ? {16'h0, retrip_dly_q} :
        (i_addr == REG_FAIL)   ? {16'h0, fail_dly_q} :
        (i_addr == REG_MASK)   ? {16'h0, off_mask_q, on_mask_q} :
        (i_addr == REG_STATUS) ? {21'h0, mon_w, state_q} :
        (i_addr == REG_C_RTR)  ? {16'h0, cnt_q[CNT_RETRIP]} :
        (i_addr == REG_C_FAIL) ? {16'h0, cnt_q[CNT_FAIL]} :
        (i_addr == REG_C_STRT) ? {16'h0, cnt_q[CNT_START]} :
        (i_addr == REG_C_BLK)  ? {16'h0, cnt_q[CNT_BLOCK]} :
        (i_addr == REG_R_SEL)  ? 32'(rec_sel_q) :
        (i_addr == REG_R_STMP) ? rec_rd_w.stamp :
        (i_addr == REG_R_INFO) ? {26'h0, rec_rd_w.group, rec_rd_w.id} :
        (i_addr == REG_R_CUR)  ? {rec_rd_w.phase, rec_rd_w.residual} :
        (i_addr == REG_R_TIME) ? {rec_rd_w.to_retrip, rec_rd_w.to_fail} :
        (i_addr == REG_R_FILL) ? 32'(fill_q) : 32'h0;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rdata_w : '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    sequence s_live_tick;
        tick_q && pick_w && !blk_w;
    endsequence

    a_cur_start: assert property (s_live_tick ##0 crit_q == CRIT_CUR |=> o_start)
        else $error("current pick-up did not start");
    a_cur_no_trip: assert property (tick_q && crit_q == CRIT_CUR && cur_w && !trip_w
        && !blk_w |=> o_start) else $error("current mode waited for trip");
    a_drop_clears: assert property (tick_q && !pick_w |=> timer_q == 16'h0 && !o_start)
        else $error("timer not cleared on drop");
    a_and_halted: assert property (tick_q && crit_q == CRIT_AND && cur_w && !trip_w
        |=> timer_q == 16'h0 && !o_start) else $error("and mode ran without contact");
    a_and_runs: assert property (s_live_tick ##0 crit_q == CRIT_AND
        |=> timer_q == $past(timer_inc_w)) else $error("and mode timer not running");
    a_and_reset: assert property (tick_q && crit_q == CRIT_AND && !(cur_w && trip_w)
        |=> timer_q == 16'h0) else $error("and mode timer not reset");
    a_or_trip_only: assert property (tick_q && crit_q == CRIT_OR && trip_w && !cur_w
        && !blk_w |=> o_start) else $error("or mode ignored contact");
    a_or_holds: assert property (tick_q && crit_q == CRIT_OR && (cur_w || trip_w)
        && !blk_w |=> timer_q != 16'h0) else $error("or mode timer cleared early");
    a_di_only: assert property (tick_q && crit_q == CRIT_DI && !filt_q[PIN_DI]
        |=> !o_start && timer_q == 16'h0) else $error("input mode ran without input");
    a_fail_expiry: assert property (s_live_tick ##0 timer_inc_w >= fail_ticks_w
        |=> o_breaker_failure_output) else $error("failure output late");
    a_retrip_expiry: assert property (s_live_tick ##0 retrip_hit_w
        |=> o_retrip ##1 o_retrip) else $error("retrip output late");
    a_block_wins: assert property (tick_q && pick_w && blk_w
        |=> o_blocked && !o_start && timer_q == 16'h0) else $error("block not taken");
    a_fail_count: assert property ($rose(o_breaker_failure_output)
        && !$past(clr_w[CNT_FAIL]) |-> cnt_q[CNT_FAIL] == $past(cnt_q[CNT_FAIL]) + 16'h1)
        else $error("failure count missed");
    a_event_out: assert property (store_w |=> o_event_valid
        && o_event.id == $past(ev_idx)) else $error("event not issued");
    a_hist_fill: assert property (rec_w && fill_q < PW'(HIST_DEPTH)
        |=> fill_q == $past(fill_q) + PW'(1)) else $error("record not kept");

endmodule

`default_nettype wire

/* breaker_failure_pkg.sv */
// Constants, types and register map of the breaker failure timer.
// Assumes a 50 MHz system clock and a 5 ms protection program cycle.

package breaker_failure_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned CYCLE_US      = 5_000;
    localparam int unsigned CYCLE_CLKS    = CYCLE_US * CLK_PER_US;
    localparam int unsigned MS_US         = 1_000;
    localparam int unsigned MS_CLKS       = MS_US * CLK_PER_US;
    localparam int unsigned STEP_US       = 5_000;
    localparam int unsigned STEP_TICKS    = STEP_US / CYCLE_US;
    localparam int unsigned RETRIP_DEF_US = 100_000;
    localparam int unsigned FAIL_DEF_US   = 200_000;
    localparam logic [15:0] RETRIP_DEF    = 16'(RETRIP_DEF_US / STEP_US);
    localparam logic [15:0] FAIL_DEF      = 16'(FAIL_DEF_US / STEP_US);
    localparam int unsigned HIST_DEF      = 12;

    // ------------------------------------------------------------
    // Criteria, control bits, pins, events, counters
    // ------------------------------------------------------------
    localparam logic [1:0]  CRIT_CUR     = 2'h0;
    localparam logic [1:0]  CRIT_AND     = 2'h1;
    localparam logic [1:0]  CRIT_OR      = 2'h2;
    localparam logic [1:0]  CRIT_DI      = 2'h3;
    localparam int unsigned CTRL_CRIT    = 0;
    localparam int unsigned CTRL_RETRIP  = 2;
    localparam int unsigned CTRL_SUP_CUR = 3;
    localparam int unsigned CTRL_SUP_DO  = 4;
    localparam logic [4:0]  CTRL_RST     = 5'h04;
    localparam logic [15:0] MASK_RST     = 16'hFFFF;
    localparam int unsigned PIN_PH   = 0;
    localparam int unsigned PIN_RES  = 1;
    localparam int unsigned PIN_TRIP = 2;
    localparam int unsigned PIN_DI   = 3;
    localparam int unsigned PIN_BLK  = 4;
    localparam int unsigned PIN_N    = 5;
    localparam int unsigned EV_N     = 8;
    localparam int unsigned CNT_RETRIP = 0;
    localparam int unsigned CNT_FAIL   = 1;
    localparam int unsigned CNT_START  = 2;
    localparam int unsigned CNT_BLOCK  = 3;
    localparam int unsigned CNT_N      = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_RETRIP = 8'h04;
    localparam logic [7:0] REG_FAIL   = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CLR    = 8'h14;
    localparam logic [7:0] REG_C_RTR  = 8'h18;
    localparam logic [7:0] REG_C_FAIL = 8'h1C;
    localparam logic [7:0] REG_C_STRT = 8'h20;
    localparam logic [7:0] REG_C_BLK  = 8'h24;
    localparam logic [7:0] REG_R_SEL  = 8'h28;
    localparam logic [7:0] REG_R_STMP = 8'h2C;
    localparam logic [7:0] REG_R_INFO = 8'h30;
    localparam logic [7:0] REG_R_CUR  = 8'h34;
    localparam logic [7:0] REG_R_TIME = 8'h38;
    localparam logic [7:0] REG_R_FILL = 8'h3C;

    typedef enum logic [2:0] {ST_NORMAL, ST_START, ST_RETRIP, ST_FAIL, ST_BLOCKED} bf_state_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [2:0]  id;
        logic        on;
    } event_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [2:0]  id;
        logic [2:0]  group;
        logic [15:0] phase;
        logic [15:0] residual;
        logic [15:0] to_retrip;
        logic [15:0] to_fail;
    } record_t;

endpackage

/* primary_stage_model.sv */
// Partner model: primary protection stage phase pick-up and trip contact.
// Assumes the bench commands fault and trip levels at clock edges.
`timescale 1ns/1ps
`default_nettype none
module primary_stage_model (
    input  wire logic i_sys_clk,
    input  wire logic i_fault,
    input  wire logic i_trip_cmd,
    output logic      o_phase_pickup,
    output logic      o_trip_contact
);
    // Contact and comparator settle a cycle late, like a real relay
    always_ff @(posedge i_sys_clk) begin
        o_phase_pickup <= i_fault;
        o_trip_contact <= i_trip_cmd;
    end
endmodule
`default_nettype wire

/* breaker_failure_timer_logic_test.sv */
// Bench for the breaker failure timer: criteria table, delays, counters.
// Assumes a short program cycle of 10 clocks and one partner model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module breaker_failure_timer_logic_test;
    import breaker_failure_pkg::*;
    logic        i_sys_clk, i_reset, fault, trip, res, trig, blk, ph, con, rd_q;
    logic [15:0] cur_ph, cur_res;
    logic [2:0]  grp;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, ev, m, seed = 32'hDFD2C726;
    logic        i_wr, i_rd, o_start, o_retrip, o_bf, o_blocked, o_ev_valid;
    event_t      o_event;
    int          err_count, cmp_count, cyc, evs;
    logic [31:0] exp_q[$];
    logic [23:0] tc[10] = '{24'h04_01_10, 24'h04_04_00, 24'h04_02_10, 24'h05_01_00,
        24'h05_05_10, 24'h06_04_10, 24'h07_08_10, 24'h07_05_00, 24'h0F_08_00, 24'h04_11_01};
    primary_stage_model PRI (.i_sys_clk(i_sys_clk), .i_fault(fault), .i_trip_cmd(trip),
        .o_phase_pickup(ph), .o_trip_contact(con));
    breaker_failure_timer_logic #(.CYCLE_CLKS_P(10), .MS_CLKS_P(4)) DUT (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_phase_pickup(ph),
        .i_residual_pickup(res), .i_trip_contact(con), .i_trigger_input(trig),
        .i_block(blk), .i_max_phase_current(cur_ph), .i_residual_current(cur_res),
        .i_setting_group(grp), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_retrip(o_retrip),
        .o_breaker_failure_output(o_bf), .o_blocked(o_blocked),
        .o_event_valid(o_ev_valid), .o_event(o_event));
    // ----------------------------------------------------------------
    // Bus tasks and helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    // Expected word is queued; the watcher compares it a cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_addr <= a; i_rd <= 1'b1; exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // Watcher: read data, event pulses and a hang ceiling
    always @(posedge i_sys_clk) begin
        rd_q <= i_rd;
        cyc <= cyc + 1;
        if (o_ev_valid === 1'b1) evs++;
        if (rd_q === 1'b1) begin
            ev = exp_q.pop_front();
            `CHK("rdata", ev, o_rdata)
        end
        if (cyc > 20000) begin
            err_count++;
            test_done();
        end
    end
    // Main sequence; delays 2 and 3 steps keep both expiries of the one timer in reach
    initial begin
        {fault, trip, res, trig, blk, i_wr, i_rd, i_addr, i_wdata, cyc, evs} = '0;
        {cur_ph, cur_res, grp} = '0;
        i_reset = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd(REG_CTRL, 32'h4);
        rd(REG_RETRIP, 32'h14);
        rd(REG_FAIL, 32'h28);
        rd(REG_MASK, 32'hFFFF);
        rd(8'h40, 32'h0);
        m = rnd();
        wr(REG_MASK, {16'h0, m[15:0] | 16'h0101});
        rd(REG_MASK, {16'h0, m[15:0] | 16'h0101});
        wr(REG_RETRIP, 32'h2);
        wr(REG_FAIL, 32'h3);
        foreach (tc[i]) begin
            wr(REG_CTRL, {24'h0, tc[i][23:16]});
            m = rnd();
            @(posedge i_sys_clk);
            {blk, trig, trip, res, fault} <= tc[i][12:8];
            {cur_ph, cur_res} <= m;
            grp <= m[2:0];
            repeat (12) @(posedge i_sys_clk);
            #1;
            `CHK("early", 1'b0, o_bf)
            repeat (48) @(posedge i_sys_clk);
            #1;
            `CHK("fail", tc[i][4], o_bf)
            `CHK("retrip", tc[i][4], o_retrip)
            `CHK("start", tc[i][4], o_start)
            `CHK("blocked", tc[i][0], o_blocked)
            @(posedge i_sys_clk);
            {blk, trig, trip, res, fault} <= 5'h00;
            repeat (30) @(posedge i_sys_clk);
            #1;
            `CHK("cleared", 2'h0, {o_bf, o_start})
            $display("case %0d done", i);
        end
        rd(REG_C_FAIL, 32'h5);
        rd(REG_C_RTR, 32'h5);
        rd(REG_C_STRT, 32'h5);
        rd(REG_C_BLK, 32'h1);
        wr(REG_CLR, 32'h2);
        rd(REG_C_FAIL, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        `CHK("events", 1'b1, evs > 0)
        test_done();
    end
endmodule
`default_nettype wire
